// file: verilog/dbc_pkg.sv
// Constants, parameter memory map and state codes of the dynamics block.
// Assumes a single 100 MHz clock and one stereo frame per input handshake.
package dbc_pkg;
  // ****************************************
  // Widths and formats
  // ****************************************
  localparam int SMP_W   = 24;
  localparam int PRM_W   = 22;
  localparam int PRM_AW  = 8;
  localparam int PRM_N   = 256;
  localparam int FRAC_W  = 20;
  localparam int MS_W    = 36;
  localparam int LOG_W   = 22;
  localparam int LFRAC_W = 16;
  localparam int HOLD_W  = 22;

  // ****************************************
  // Parameter memory map
  // ****************************************
  localparam logic [7:0] MAIN_TBL  = 8'h6E;
  localparam logic [7:0] MAIN_BASE = 8'h5A;
  localparam logic [7:0] SUB_TBL   = 8'hA0;
  localparam logic [7:0] SUB_BASE  = 8'hC8;
  localparam logic [7:0] OFS_TC    = 8'h00;
  localparam logic [7:0] OFS_HOLD  = 8'h01;
  localparam logic [7:0] OFS_REL   = 8'h02;
  localparam logic [7:0] OFS_DLY   = 8'h03;
  localparam logic [7:0] OFS_POST  = 8'h04;
  localparam logic [7:0] OFS_LW    = 8'h09;
  localparam logic [7:0] OFS_RW    = 8'h0A;
  localparam logic [7:0] OFS_BQ    = 8'h0B;
  localparam logic [PRM_W-1:0] PRM_RST = 22'h000000;

  // ****************************************
  // Counts
  // ****************************************
  localparam logic [5:0] TBL_LAST  = 6'h20;
  localparam logic [5:0] LOG_OFS   = 6'h02;
  localparam logic [6:0] DLY_N     = 7'h64;
  localparam logic [2:0] POST_LAST = 3'h4;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 48;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DET  = 6'h02,
    ST_GAIN = 6'h04,
    ST_MUL  = 6'h08,
    ST_POST = 6'h10,
    ST_OUT  = 6'h20
  } dbc_state_e;
endpackage

// file: verilog/dbc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; read data is valid while rd_valid is high.
`timescale 1ns/10ps
module dbc_fifo #(
  parameter int W     = 48,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  // Drain side
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW:0]  wp_ff;
  logic [AW:0]  rp_ff;
  logic         ready_ff;
  logic         do_wr;
  logic         do_rd;
  logic [AW:0]  nxt_wp;
  logic [AW:0]  nxt_rp;

  assign do_wr    = wr_valid & ready_ff;
  assign do_rd    = rd_ready & rd_valid;
  assign nxt_wp   = wp_ff + (AW+1)'(do_wr);
  assign nxt_rp   = rp_ff + (AW+1)'(do_rd);
  assign wr_ready = ready_ff;
  assign rd_valid = wp_ff != rp_ff;
  assign rd_data  = mem[rp_ff[AW-1:0]];

  // Ready is registered so the ready seen upstream leaves a flop directly
  always_ff @(posedge mclk) begin
    if (rst) begin
      wp_ff    <= '0;
      rp_ff    <= '0;
      ready_ff <= 1'b1;
    end else begin
      wp_ff    <= nxt_wp;
      rp_ff    <= nxt_rp;
      ready_ff <= (nxt_wp[AW] == nxt_rp[AW]) || (nxt_wp[AW-1:0] != nxt_rp[AW-1:0]);
    end
  end

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wp_ff[AW-1:0]] <= wr_data;
    end
  end
endmodule

// file: verilog/dbc_dynamics.sv
// Two-band dynamics processor: main left/right and subwoofer compressors.
// Assumes frames arrive by valid/ready and the host fills parameter memory.
`timescale 1ns/10ps

// Notes on behaviour
// - Detector envelope rides peaks of the rms log level, then holds, then releases.
// - Each detector uses time constant, hold and release words from memory.
// - Log level upper bits pick a table entry; lower bits interpolate to next.
// - Table has 33 entries, 3 dB per step, 96 dB span.
// - Main compressor table sits at parameter addresses 110 to 142.
// - Top address means +9 dB, bottom address means -87 dB.
// - Table entries are signed 2.20 linear gains, just under 2.0.
// - Main signal is delayed before the gain multiplier, detector is not.
// - Main detector input is (left plus right) halved.
// - Five cascaded post-gain multipliers follow each compressor.
// - Table, post-gain, weight, biquad and time-constant words are 22-bit signed 2.20.
// - Hold word is a sample count waited before release begins.
// - Look-ahead word counts samples and never exceeds 100.
// - Sub input is a weighted sum of left and right.
// - Sub detector input passes a biquad; audio path is untouched.
// - Sub signal reaches its multiplier with no look-ahead delay.
// - A 100-sample delay line exists only on the two main channels.
module dbc_dynamics (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  // Input frames
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic signed [23:0]           in_left,
  input  wire logic signed [23:0]           in_right,
  // Parameter memory write port
  input  wire logic                         prm_we,
  input  wire logic [dbc_pkg::PRM_AW-1:0]   prm_addr,
  input  wire logic [dbc_pkg::PRM_W-1:0]    prm_wdata,
  // Output frames
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic signed [23:0]                out_left,
  output logic signed [23:0]                out_right,
  output logic signed [23:0]                out_sub
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic signed [23:0] sat24(input logic signed [63:0] v);
    if (v > 64'sd8388607) begin
      sat24 = 24'sh7FFFFF;
    end else if (v < -64'sd8388608) begin
      sat24 = -24'sh800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  function automatic logic [5:0] lead1(input logic [35:0] v);
    lead1 = 6'h00;
    for (int i = 0; i < 36; i++) begin
      if (v[i]) begin
        lead1 = 6'(i);
      end
    end
  endfunction

  // ****************************************
  // Input FIFO and parameter memory
  // ****************************************
  dbc_pkg::dbc_state_e state_ff;
  logic [47:0]              fifo_data;
  logic                     fifo_valid;
  logic                     fifo_pop;
  logic [dbc_pkg::PRM_W-1:0] prm_mem [0:dbc_pkg::PRM_N-1];

  assign fifo_pop = state_ff == dbc_pkg::ST_IDLE;

  dbc_fifo #(.W(dbc_pkg::FIFO_W), .DEPTH(dbc_pkg::FIFO_DEPTH)) u_fifo (
    .mclk     (mclk),
    .rst      (rst),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .wr_data  ({in_left, in_right}),
    .rd_valid (fifo_valid),
    .rd_ready (fifo_pop),
    .rd_data  (fifo_data)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < dbc_pkg::PRM_N; i++) begin
        prm_mem[i] <= dbc_pkg::PRM_RST;
      end
    end else if (prm_we) begin
      prm_mem[prm_addr] <= prm_wdata;
    end
  end

  // ****************************************
  // Frame sequencer
  // ****************************************
  logic signed [23:0] l_ff;
  logic signed [23:0] r_ff;
  logic [2:0]         post_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff  <= dbc_pkg::ST_IDLE;
      post_ff   <= 3'h0;
      l_ff      <= 24'sh000000;
      r_ff      <= 24'sh000000;
      out_valid <= 1'b0;
    end else begin
      case (state_ff)
        dbc_pkg::ST_IDLE: begin
          if (fifo_valid) begin
            l_ff     <= fifo_data[47:24];
            r_ff     <= fifo_data[23:0];
            state_ff <= dbc_pkg::ST_DET;
          end
        end
        dbc_pkg::ST_DET:  state_ff <= dbc_pkg::ST_GAIN;
        dbc_pkg::ST_GAIN: state_ff <= dbc_pkg::ST_MUL;
        dbc_pkg::ST_MUL: begin
          post_ff  <= 3'h0;
          state_ff <= dbc_pkg::ST_POST;
        end
        dbc_pkg::ST_POST: begin
          post_ff <= post_ff + 3'h1;
          if (post_ff == dbc_pkg::POST_LAST) begin
            out_valid <= 1'b1;
            state_ff  <= dbc_pkg::ST_OUT;
          end
        end
        dbc_pkg::ST_OUT: begin
          // Holding here stalls the FIFO drain, so back-pressure reaches in_ready
          if (out_ready) begin
            out_valid <= 1'b0;
            state_ff  <= dbc_pkg::ST_IDLE;
          end
        end
        default: state_ff <= dbc_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Detector and signal inputs
  // ****************************************
  logic signed [24:0] lr_sum;
  logic signed [23:0] det_main;
  logic signed [46:0] mix_acc;
  logic signed [23:0] sub_mix;
  logic signed [23:0] bq_x1_ff, bq_x2_ff, bq_y1_ff, bq_y2_ff;
  logic signed [48:0] bq_acc;
  logic signed [23:0] bq_y;
  logic signed [23:0] det_in [0:1];

  assign lr_sum   = 25'(l_ff) + 25'(r_ff);
  assign det_main = lr_sum[24:1];
  assign mix_acc  = 47'($signed(prm_mem[dbc_pkg::SUB_BASE + dbc_pkg::OFS_LW]) * l_ff)
                  + 47'($signed(prm_mem[dbc_pkg::SUB_BASE + dbc_pkg::OFS_RW]) * r_ff);
  assign sub_mix  = sat24(64'(mix_acc >>> dbc_pkg::FRAC_W));
  assign bq_acc = 49'($signed(prm_mem[dbc_pkg::SUB_BASE + dbc_pkg::OFS_BQ]) * sub_mix)
                + 49'($signed(prm_mem[dbc_pkg::SUB_BASE + dbc_pkg::OFS_BQ + 8'h01]) * bq_x1_ff)
                + 49'($signed(prm_mem[dbc_pkg::SUB_BASE + dbc_pkg::OFS_BQ + 8'h02]) * bq_x2_ff)
                - 49'($signed(prm_mem[dbc_pkg::SUB_BASE + dbc_pkg::OFS_BQ + 8'h03]) * bq_y1_ff)
                - 49'($signed(prm_mem[dbc_pkg::SUB_BASE + dbc_pkg::OFS_BQ + 8'h04]) * bq_y2_ff);
  assign bq_y   = sat24(64'(bq_acc >>> dbc_pkg::FRAC_W));
  assign det_in[0] = det_main;
  assign det_in[1] = bq_y;

  always_ff @(posedge mclk) begin
    if (rst) begin
      bq_x1_ff <= 24'sh000000;
      bq_x2_ff <= 24'sh000000;
      bq_y1_ff <= 24'sh000000;
      bq_y2_ff <= 24'sh000000;
    end else if (state_ff == dbc_pkg::ST_DET) begin
      bq_x1_ff <= sub_mix;
      bq_x2_ff <= bq_x1_ff;
      bq_y1_ff <= bq_y;
      bq_y2_ff <= bq_y1_ff;
    end
  end

  // ****************************************
  // Look-ahead delay, main channels only
  // ****************************************
  logic [47:0]        dl_mem [0:99];
  logic [6:0]         dl_wp_ff;
  logic [6:0]         dly_raw;
  logic [6:0]         dly;
  logic [6:0]         dl_rp;
  logic [47:0]        dl_out;
  logic signed [23:0] dl_l_ff;
  logic signed [23:0] dl_r_ff;

  assign dly_raw = prm_mem[dbc_pkg::MAIN_BASE + dbc_pkg::OFS_DLY][6:0];
  assign dly    = (|prm_mem[dbc_pkg::MAIN_BASE + dbc_pkg::OFS_DLY][21:7]
                  || dly_raw > dbc_pkg::DLY_N) ? dbc_pkg::DLY_N : dly_raw;
  assign dl_rp  = (dl_wp_ff >= dly) ? dl_wp_ff - dly : dl_wp_ff + dbc_pkg::DLY_N - dly;
  assign dl_out = (dly == 7'h00) ? {l_ff, r_ff} : dl_mem[dl_rp];

  always_ff @(posedge mclk) begin
    if (rst) begin
      dl_wp_ff <= 7'h00;
      dl_l_ff  <= 24'sh000000;
      dl_r_ff  <= 24'sh000000;
    end else if (state_ff == dbc_pkg::ST_DET) begin
      dl_l_ff  <= dl_out[47:24];
      dl_r_ff  <= dl_out[23:0];
      dl_wp_ff <= (dl_wp_ff == dbc_pkg::DLY_N - 7'h01) ? 7'h00 : dl_wp_ff + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (state_ff == dbc_pkg::ST_DET) begin
      dl_mem[dl_wp_ff] <= {l_ff, r_ff};
    end
  end

  // ****************************************
  // Detectors and gain tables, one per band
  // ****************************************
  logic signed [21:0] gain [0:1];

  for (genvar c = 0; c < 2; c++) begin : g_band
    localparam logic [7:0] BASE = (c == 0) ? dbc_pkg::MAIN_BASE : dbc_pkg::SUB_BASE;
    localparam logic [7:0] TBL  = (c == 0) ? dbc_pkg::MAIN_TBL : dbc_pkg::SUB_TBL;
    logic [35:0]        ms_ff;
    logic [21:0]        env_ff;
    logic [21:0]        hold_ff;
    logic [47:0]        sq;
    logic signed [36:0] ms_diff;
    logic signed [58:0] ms_prod;
    logic signed [39:0] ms_sum;
    logic [35:0]        nxt_ms;
    logic [5:0]         pos;
    logic [35:0]        norm;
    logic [21:0]        cur_log;
    logic [21:0]        rel;
    logic [21:0]        env_dec;
    logic [5:0]         i0;
    logic [5:0]         i1;
    logic signed [22:0] t_diff;
    logic signed [39:0] t_prod;

    assign sq      = 48'(det_in[c] * det_in[c]);
    assign ms_diff = $signed({3'h0, sq[47:14]}) - $signed({1'b0, ms_ff});
    assign ms_prod = ms_diff * $signed(prm_mem[BASE + dbc_pkg::OFS_TC]);
    assign ms_sum  = 40'($signed({4'h0, ms_ff})) + 40'(ms_prod >>> dbc_pkg::FRAC_W);
    assign nxt_ms  = ms_sum[39] ? 36'h0 : (|ms_sum[38:36]) ? '1 : ms_sum[35:0];
    // 3 dB per power of two; full-scale square (1.0) is +3 dB
    assign pos     = lead1(ms_ff);
    assign norm    = ms_ff << (6'd35 - pos);
    assign cur_log = (pos < dbc_pkg::LOG_OFS) ? 22'h0 : {pos - dbc_pkg::LOG_OFS, norm[34:19]};
    assign rel     = prm_mem[BASE + dbc_pkg::OFS_REL];
    assign env_dec = (env_ff > rel) ? env_ff - rel : 22'h0;

    always_ff @(posedge mclk) begin
      if (rst) begin
        ms_ff   <= 36'h0;
        env_ff  <= 22'h0;
        hold_ff <= 22'h0;
      end else if (state_ff == dbc_pkg::ST_DET) begin
        ms_ff <= nxt_ms;
      end else if (state_ff == dbc_pkg::ST_GAIN) begin
        if (cur_log >= env_ff) begin
          env_ff  <= cur_log;
          hold_ff <= prm_mem[BASE + dbc_pkg::OFS_HOLD];
        end else if (hold_ff != 22'h0) begin
          hold_ff <= hold_ff - 22'h1;
        end else begin
          env_ff <= (env_dec > cur_log) ? env_dec : cur_log;
        end
      end
    end

    assign i0     = (env_ff[21:16] >= dbc_pkg::TBL_LAST) ? dbc_pkg::TBL_LAST : env_ff[21:16];
    assign i1     = (i0 == dbc_pkg::TBL_LAST) ? i0 : i0 + 6'h1;
    assign t_diff = 23'($signed(prm_mem[TBL + 8'(i1)])) - 23'($signed(prm_mem[TBL + 8'(i0)]));
    assign t_prod = t_diff * $signed({1'b0, env_ff[15:0]});
    assign gain[c] = $signed(prm_mem[TBL + 8'(i0)]) + 22'(t_prod >>> dbc_pkg::LFRAC_W);
  end

  // ****************************************
  // Gain multiply and post gain, per lane
  // ****************************************
  logic signed [23:0] y_ff [0:2];

  for (genvar k = 0; k < 3; k++) begin : g_lane
    localparam int BAND = (k == 2) ? 1 : 0;
    localparam logic [7:0] BASE = (k == 2) ? dbc_pkg::SUB_BASE : dbc_pkg::MAIN_BASE;
    logic signed [23:0] src;
    logic signed [45:0] g_prod;
    logic signed [45:0] p_prod;

    assign src    = (k == 0) ? dl_l_ff : (k == 1) ? dl_r_ff : sub_mix;
    assign g_prod = src * gain[BAND];
    assign p_prod = y_ff[k] * $signed(prm_mem[BASE + dbc_pkg::OFS_POST + 8'(post_ff)]);

    always_ff @(posedge mclk) begin
      if (rst) begin
        y_ff[k] <= 24'sh000000;
      end else if (state_ff == dbc_pkg::ST_MUL) begin
        y_ff[k] <= sat24(64'(g_prod >>> dbc_pkg::FRAC_W));
      end else if (state_ff == dbc_pkg::ST_POST) begin
        y_ff[k] <= sat24(64'(p_prod >>> dbc_pkg::FRAC_W));
      end
    end
  end

  // Outputs are the lane flops, frozen while the frame is offered
  assign out_left  = y_ff[0];
  assign out_right = y_ff[1];
  assign out_sub   = y_ff[2];
endmodule

// file: dv/dbc_src_model.sv
// Upstream frame source and parameter host for the dynamics block.
// Assumes the caller owns the clock; all requests move 1 ns after a rising edge.
`timescale 1ns/10ps
module dbc_src_model (
  // Clock
  input  wire logic                  mclk,
  // Frames toward the block
  input  wire logic                  in_ready,
  output logic                       in_valid,
  output logic signed [23:0]         in_left,
  output logic signed [23:0]         in_right,
  // Parameter writes
  output logic                       prm_we,
  output logic [dbc_pkg::PRM_AW-1:0] prm_addr,
  output logic [dbc_pkg::PRM_W-1:0]  prm_wdata
);
  initial begin
    in_valid  = 1'b0;
    in_left   = 24'h000000;
    in_right  = 24'h000000;
    prm_we    = 1'b0;
    prm_addr  = 8'h00;
    prm_wdata = 22'h000000;
  end

  task automatic wr(input logic [7:0] a, input logic [21:0] d);
    @(posedge mclk);
    #1 prm_we = 1'b1;
    prm_addr  = a;
    prm_wdata = d;
    @(posedge mclk);
    #1 prm_we = 1'b0;
    // Released lines never keep their old value
    prm_addr  = ~a;
    prm_wdata = ~d;
  endtask

  task automatic det_cfg(input logic [7:0] b, input logic [21:0] tc, hold, rel, dly);
    logic [21:0] d;
    d = (dly > 22'h000064) ? 22'h000064 : dly;
    wr(b + dbc_pkg::OFS_TC, tc);
    wr(b + dbc_pkg::OFS_HOLD, (hold < d) ? d : hold);
    wr(b + dbc_pkg::OFS_REL, rel);
    wr(b + dbc_pkg::OFS_DLY, d);
  endtask

  task automatic send(input logic signed [23:0] l, r, output logic ok);
    int i;
    @(posedge mclk);
    #1 in_valid = 1'b1;
    in_left  = l;
    in_right = r;
    ok = 1'b0;
    for (i = 0; i < 200 && !ok; i++) begin
      @(negedge mclk);
      ok = (in_ready === 1'b1);
    end
    @(posedge mclk);
    #1 in_valid = 1'b0;
    in_left  = ~l;
    in_right = ~r;
  endtask
endmodule

// file: dv/dbc_dyn_assertions.sv
// Port-level checks of the dynamics block, bound to its top module.
// Assumes one clock mclk and synchronous active-high rst.
`timescale 1ns/10ps
module dbc_dyn_chk (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst,
  // Handshakes
  input wire logic               in_valid,
  input wire logic               in_ready,
  input wire logic               prm_we,
  input wire logic               out_valid,
  input wire logic               out_ready,
  // Results
  input wire logic signed [23:0] out_left,
  input wire logic signed [23:0] out_right,
  input wire logic signed [23:0] out_sub
);
  // ************************
  // Frames in flight
  // ************************
  logic [3:0] pend_ff;
  logic [3:0] nxt_pend;
  logic       seen_ff;
  assign nxt_pend = pend_ff + 4'(in_valid && in_ready) - 4'(out_valid && out_ready);
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_ff <= 4'h0;
      seen_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      seen_ff <= seen_ff | prm_we;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ************************
  // Assertions
  // ************************
  // result holds
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid &&
    $stable(out_left) && $stable(out_right) && $stable(out_sub)) else $error("result moved");
  chk_take_drop: assert property (out_valid && out_ready |=> !out_valid)
    else $error("result not released");
  chk_post_gap: assert property ($fell(out_valid) |-> !out_valid[*8])
    else $error("frame too fast");
  chk_no_spurious: assert property (!out_valid && pend_ff == 4'h0 |=> !out_valid)
    else $error("spurious result");
  chk_fifo_cap: assert property (pend_ff <= 4'h9)
    else $error("frame taken while full");
  chk_ready_empty: assert property (pend_ff == 4'h0 |-> in_ready)
    else $error("ready low while empty");
  chk_lat_bound: assert property (!out_valid && pend_ff != 4'h0 |-> ##[0:12] out_valid)
    else $error("result late");
  chk_silent_gain: assert property (!seen_ff && out_valid |-> out_left == 24'h000000 &&
    out_right == 24'h000000 && out_sub == 24'h000000) else $error("output not silent");
  cover property (out_valid && !out_ready);
  cover property (!in_ready);
  cover property (out_valid && out_ready);
endmodule

bind dbc_dynamics dbc_dyn_chk u_chk (.mclk(mclk), .rst(rst), .in_valid(in_valid),
  .in_ready(in_ready), .prm_we(prm_we), .out_valid(out_valid), .out_ready(out_ready),
  .out_left(out_left), .out_right(out_right), .out_sub(out_sub));

// file: dv/dbc_dynamics_tb.sv
// Self-checking bench of the dynamics block driven by the source model.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/10ps
module dbc_dynamics_tb;
  logic                       mclk;
  logic                       rst;
  logic                       in_valid;
  logic                       in_ready;
  logic signed [23:0]         in_left;
  logic signed [23:0]         in_right;
  logic                       prm_we;
  logic [dbc_pkg::PRM_AW-1:0] prm_addr;
  logic [dbc_pkg::PRM_W-1:0]  prm_wdata;
  logic                       out_valid;
  logic                       out_ready;
  logic signed [23:0]         out_left;
  logic signed [23:0]         out_right;
  logic signed [23:0]         out_sub;
  logic signed [23:0]         ql[$];
  logic signed [23:0]         qr[$];
  int                         n_errors;
  int                         total_checks;
  int                         rx;
  int                         sh;
  int                         dly;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

  dbc_dynamics u_dut (.mclk(mclk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
    .in_left(in_left), .in_right(in_right), .prm_we(prm_we), .prm_addr(prm_addr),
    .prm_wdata(prm_wdata), .out_valid(out_valid), .out_ready(out_ready),
    .out_left(out_left), .out_right(out_right), .out_sub(out_sub));
  dbc_src_model u_src (.mclk(mclk), .in_ready(in_ready), .in_valid(in_valid),
    .in_left(in_left), .in_right(in_right), .prm_we(prm_we), .prm_addr(prm_addr),
    .prm_wdata(prm_wdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ************************
  // Shared tasks
  // ************************
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic tx(input logic signed [23:0] l, r);
    logic ok;
    u_src.send(l, r, ok);
    ql.push_back(l);
    qr.push_back(r);
    if (!ok) begin
      n_errors++;
      print_verdict();
    end
  endtask

  task automatic get;
    int i;
    @(posedge mclk);
    #1 out_ready = 1'b1;
    for (i = 0; i < 200 && out_valid !== 1'b1; i++) @(negedge mclk);
    if (out_valid !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
  endtask

  task automatic ack;
    rx++;
    @(posedge mclk);
    #1 out_ready = 1'b0;
  endtask

  task automatic rx_chk;
    get();
    `CHK("left", ql[rx - dly] >>> sh, out_left)
    `CHK("right", qr[rx - dly] >>> sh, out_right)
    `CHK("sub", 24'(ql[rx] + qr[rx]), out_sub)
    ack();
  endtask

  task automatic fill(input logic [7:0] a, input int n, input logic [21:0] v);
    int i;
    for (i = 0; i < n; i++) u_src.wr(a + 8'(i), v);
  endtask

  // ************************
  // Scenarios
  // ************************
  task automatic t_silent;
    `CHK("ready", 1'b1, in_ready)
    tx(24'h123456, 24'h654320);
    get();
    `CHK("left", 24'h000000, out_left)
    `CHK("sub", 24'h000000, out_sub)
    ack();
  endtask

  task automatic t_unity;
    fill(dbc_pkg::MAIN_TBL, 33, 22'h100000);
    fill(dbc_pkg::SUB_TBL, 33, 22'h100000);
    fill(dbc_pkg::MAIN_BASE + dbc_pkg::OFS_POST, 5, 22'h100000);
    fill(dbc_pkg::SUB_BASE + dbc_pkg::OFS_POST, 5, 22'h100000);
    fill(dbc_pkg::SUB_BASE + dbc_pkg::OFS_LW, 2, 22'h100000);
    tx(24'h123456, 24'h000100);
    tx(24'hF00000, 24'h054320);
    tx(24'h7FFFFF, 24'h800000);
    repeat (3) rx_chk();
  endtask

  // Out-of-table words catch a misplaced index
  task automatic t_levels;
    u_src.wr(dbc_pkg::MAIN_TBL - 8'h01, 22'h300000);
    u_src.wr(dbc_pkg::MAIN_TBL + 8'h21, 22'h300000);
    fill(dbc_pkg::MAIN_TBL, 33, 22'h080000);
    u_src.wr(dbc_pkg::MAIN_BASE + dbc_pkg::OFS_POST + 8'h04, 22'h080000);
    u_src.det_cfg(dbc_pkg::MAIN_BASE, 22'h100000, 22'h000000, 22'h000400, 22'h000000);
    u_src.det_cfg(dbc_pkg::SUB_BASE, 22'h100000, 22'h000000, 22'h000400, 22'h000000);
    u_src.wr(dbc_pkg::SUB_BASE + dbc_pkg::OFS_BQ, 22'h100000);
    sh = 2;
    tx(24'h400000, 24'h100000);
    tx(24'h000400, 24'h000800);
    tx(24'hFFF800, 24'hFFF000);
    repeat (3) rx_chk();
  endtask

  task automatic t_delay;
    u_src.det_cfg(dbc_pkg::MAIN_BASE, 22'h100000, 22'h000000, 22'h000400, 22'h000002);
    dly = 2;
    tx(24'h011100, 24'hFEE000);
    tx(24'h022200, 24'hFDD000);
    tx(24'h033300, 24'hFCC000);
    repeat (3) rx_chk();
  endtask

  // Consumer stalls until the buffer refuses
  task automatic t_stall;
    int i;
    for (i = 1; i < 10; i++) tx(24'(i * 4096), 24'(i * 256));
    repeat (2) @(posedge mclk);
    `CHK("ready", 1'b0, in_ready)
    repeat (9) rx_chk();
    `CHK("ready", 1'b1, in_ready)
  endtask

  // Earlier frames sit lower, so the first peak is taken at once
  task automatic t_curve;
    u_src.det_cfg(dbc_pkg::MAIN_BASE, 22'h100000, 22'h000000, 22'h000400, 22'h000000);
    u_src.wr(dbc_pkg::MAIN_TBL + 8'h1C, 22'h100000);
    u_src.wr(dbc_pkg::MAIN_BASE + dbc_pkg::OFS_POST + 8'h04, 22'h100000);
    // Mean square 9/64: entry 27, one eighth towards entry 28
    tx(24'h300000, 24'h300000);
    get();
    `CHK("left", 24'h1B0000, out_left)
    `CHK("right", 24'h1B0000, out_right)
    `CHK("sub", 24'h600000, out_sub)
    ack();
    // Quieter frame: envelope only releases 1/64 step from the peak
    tx(24'h100000, 24'h100000);
    get();
    `CHK("left", 24'h08E000, out_left)
    `CHK("sub", 24'h200000, out_sub)
    ack();
  endtask

  initial begin
    n_errors = 0;
    total_checks = 0;
    rx = 0;
    sh = 0;
    dly = 0;
    rst = 1'b1;
    out_ready = 1'b0;
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    t_silent();
    t_unity();
    t_levels();
    t_delay();
    t_stall();
    t_curve();
    print_verdict();
  end
endmodule
